// ---- src/pec_top.sv ----
// port edge change interrupt block with register port
`timescale 1ns/1ps
`default_nettype none
`include "pec_params.svh"
module pec_top (
   input  wire logic                     ref_clk,
   input  wire logic                     rst_n,
   input  wire pec_pkg::pec_pins_t       port_pin_input,
   input  wire logic [`PEC_ADDR_W-1:0]   reg_addr,
   input  wire pec_pkg::pec_byte_t       reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output var  pec_pkg::pec_byte_t       reg_rdata,
   output var  logic                     change_irq,
   output var  logic                     wake_req,
   output var  logic                     change_aggregate_flag,
   output var  logic                     irq
);
   pec_pkg::pec_pins_t rising_edge_enable_q;
   pec_pkg::pec_pins_t falling_edge_enable_q;
   logic               change_master_enable_q;
   logic [1:0]         irq_stat_q;
   logic [1:0]         irq_mask_q;
   pec_pkg::pec_pins_t rise;
   pec_pkg::pec_pins_t fall;
   pec_pkg::pec_pins_t flags;
   pec_pkg::pec_pins_t hits;
   pec_pkg::pec_pins_t flags_next;
   logic               wr_flags;
   logic               agg_d;
   logic [1:0]         evt;
   logic [1:0]         stat_d;
   logic [1:0]         mask_d;

   function automatic logic hit(input logic [`PEC_ADDR_W-1:0] a,
                                input logic [`PEC_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   pec_edge_detect u_edge (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pins    (port_pin_input),
      .rise    (rise),
      .fall    (fall)
   );

   assign wr_flags = reg_wr && hit(reg_addr, `PEC_OFF_FLAGS);

   pec_flag_bank u_flags (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .rise     (rise),
      .fall     (fall),
      .rise_en  (rising_edge_enable_q),
      .fall_en  (falling_edge_enable_q),
      .wr_flags (wr_flags),
      .wr_data  (reg_wdata[5:0]),
      .flags    (flags),
      .hits     (hits)
   );

   // enable registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rising_edge_enable_q  <= `PEC_RST_PINS;
         falling_edge_enable_q <= `PEC_RST_PINS;
         change_master_enable_q <= 1'b0;
         irq_mask_q            <= 2'h0;
      end else if (reg_wr) begin
         if (hit(reg_addr, `PEC_OFF_RISE)) begin
            rising_edge_enable_q <= reg_wdata[5:0];
         end else if (hit(reg_addr, `PEC_OFF_FALL)) begin
            falling_edge_enable_q <= reg_wdata[5:0];
         end else if (hit(reg_addr, `PEC_OFF_CTRL)) begin
            change_master_enable_q <= reg_wdata[`PEC_CTRL_MEN_BIT];
         end else if (hit(reg_addr, `PEC_OFF_IRQ_MASK)) begin
            irq_mask_q <= reg_wdata[1:0];
         end
      end
   end

   // next flag value, so outputs line up with the stored flags
   always_comb begin
      if (wr_flags) begin
         flags_next = reg_wdata[5:0] | hits;
      end else begin
         flags_next = flags | hits;
      end
      agg_d = |flags_next;
      evt   = {agg_d & ~(|flags), |hits};
      stat_d = irq_stat_q | evt;
      if (reg_wr && hit(reg_addr, `PEC_OFF_IRQ_STAT)) begin
         stat_d = (irq_stat_q & ~reg_wdata[1:0]) | evt;
      end
      mask_d = irq_mask_q;
      if (reg_wr && hit(reg_addr, `PEC_OFF_IRQ_MASK)) begin
         mask_d = reg_wdata[1:0];
      end
   end

   // interrupt, wake and aggregate outputs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         change_aggregate_flag <= 1'b0;
         change_irq            <= 1'b0;
         wake_req              <= 1'b0;
         irq_stat_q            <= 2'h0;
         irq                   <= 1'b0;
      end else begin
         change_aggregate_flag <= agg_d;
         change_irq            <= agg_d && change_master_enable_q;
         wake_req              <= agg_d && change_master_enable_q;
         irq_stat_q            <= stat_d;
         irq                   <= |(stat_d & mask_d);
      end
   end

   // read port, data in the following cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `PEC_RST_BYTE;
      end else if (reg_rd) begin
         if (hit(reg_addr, `PEC_OFF_RISE)) begin
            reg_rdata <= {2'b00, rising_edge_enable_q};
         end else if (hit(reg_addr, `PEC_OFF_FALL)) begin
            reg_rdata <= {2'b00, falling_edge_enable_q};
         end else if (hit(reg_addr, `PEC_OFF_FLAGS)) begin
            reg_rdata <= {2'b00, flags};
         end else if (hit(reg_addr, `PEC_OFF_CTRL)) begin
            reg_rdata <= {6'h00, change_aggregate_flag, change_master_enable_q};
         end else if (hit(reg_addr, `PEC_OFF_IRQ_STAT)) begin
            reg_rdata <= {6'h00, irq_stat_q};
         end else if (hit(reg_addr, `PEC_OFF_IRQ_MASK)) begin
            reg_rdata <= {6'h00, irq_mask_q};
         end else begin
            reg_rdata <= `PEC_RST_BYTE;
         end
      end else begin
         reg_rdata <= `PEC_RST_BYTE;
      end
   end
endmodule : pec_top
`default_nettype wire

// ---- src/pec_params.svh ----
// constants for the port edge change interrupt block
// Notes on behaviour
// - The core wake request rises on a change sequence only while the master enable is set.
// - An edge seen in sleep is already stored in the flag register when the wake request rises.
// - The rising enable register holds one arming bit per pin in bits five to zero.
// - The falling enable register holds one arming bit per pin in bits five to zero.
// - A pin flag is set by a rising edge with its rising enable or a falling edge with its falling enable.
// - Writing zero to a flag bit clears it and it stays zero until another enabled edge.
// - Bits seven and six of the three change registers are unimplemented and read zero.
// - The aggregate flag is the OR of all pin flags.
// - Edge detection and flag setting go on while the master enable is clear.
// - An edge arriving during a clearing write leaves its flag set whatever is written.
`ifndef PEC_PARAMS_SVH
`define PEC_PARAMS_SVH
`define PEC_NPINS        6
`define PEC_ADDR_W       3
`define PEC_OFF_RISE     3'h0
`define PEC_OFF_FALL     3'h1
`define PEC_OFF_FLAGS    3'h2
`define PEC_OFF_CTRL     3'h3
`define PEC_OFF_IRQ_STAT 3'h4
`define PEC_OFF_IRQ_MASK 3'h5
`define PEC_CTRL_MEN_BIT 0
`define PEC_CTRL_AGG_BIT 1
`define PEC_RST_BYTE     8'h00
`define PEC_RST_PINS     6'h00
`endif

// ---- src/pec_pkg.sv ----
// types for the port edge change interrupt block
`default_nettype none
package pec_pkg;
   typedef logic [5:0] pec_pins_t;
   typedef logic [7:0] pec_byte_t;
endpackage : pec_pkg
`default_nettype wire

// ---- src/pec_edge_detect.sv ----
// pin synchroniser and edge finder
`timescale 1ns/1ps
`default_nettype none
`include "pec_params.svh"
module pec_edge_detect (
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   input  wire pec_pkg::pec_pins_t pins,
   output var  pec_pkg::pec_pins_t rise,
   output var  pec_pkg::pec_pins_t fall
);
   pec_pkg::pec_pins_t s1_q;
   pec_pkg::pec_pins_t s2_q;
   pec_pkg::pec_pins_t prev_q;
   logic [2:0]         fill_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q   <= `PEC_RST_PINS;
         s2_q   <= `PEC_RST_PINS;
         prev_q <= `PEC_RST_PINS;
      end else begin
         s1_q   <= pins;
         s2_q   <= s1_q;
         prev_q <= s2_q;
      end
   end

   // no false edge while the pipe still holds reset values
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fill_q <= 3'h0;
      end else begin
         fill_q <= {fill_q[1:0], 1'b1};
      end
   end

   always_comb begin
      rise = s2_q & ~prev_q & {6{fill_q[2]}};
      fall = ~s2_q & prev_q & {6{fill_q[2]}};
   end
endmodule : pec_edge_detect
`default_nettype wire

// ---- src/pec_flag_bank.sv ----
// per pin sticky change flags
`timescale 1ns/1ps
`default_nettype none
`include "pec_params.svh"
module pec_flag_bank (
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   input  wire pec_pkg::pec_pins_t rise,
   input  wire pec_pkg::pec_pins_t fall,
   input  wire pec_pkg::pec_pins_t rise_en,
   input  wire pec_pkg::pec_pins_t fall_en,
   input  wire logic               wr_flags,
   input  wire pec_pkg::pec_pins_t wr_data,
   output var  pec_pkg::pec_pins_t flags,
   output var  pec_pkg::pec_pins_t hits
);
   pec_pkg::pec_pins_t flags_q;

   always_comb begin
      hits  = (rise & rise_en) | (fall & fall_en);
      flags = flags_q;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= `PEC_RST_PINS;
      end else if (wr_flags) begin
         flags_q <= wr_data | hits;
      end else begin
         flags_q <= flags_q | hits;
      end
   end
endmodule : pec_flag_bank
`default_nettype wire

// ---- verification/pec_pin_model.sv ----
// pin level model for the six port pins
`timescale 1ns/1ps
`default_nettype none
module pec_pin_model (
   input  wire pec_pkg::pec_pins_t want,
   output wire pec_pkg::pec_pins_t pins
);
   assign #3 pins = want;
endmodule : pec_pin_model
`default_nettype wire

// ---- verification/pec_top_chk.sv ----
// port checker for the edge change block
`timescale 1ns/1ps
`default_nettype none
`include "pec_params.svh"
module pec_top_chk (
   input wire logic                   ref_clk,
   input wire logic                   rst_n,
   input wire pec_pkg::pec_pins_t     port_pin_input,
   input wire logic [`PEC_ADDR_W-1:0] reg_addr,
   input wire pec_pkg::pec_byte_t     reg_wdata,
   input wire logic                   reg_wr,
   input wire logic                   reg_rd,
   input wire pec_pkg::pec_byte_t     reg_rdata,
   input wire logic                   change_irq,
   input wire logic                   wake_req,
   input wire logic                   change_aggregate_flag,
   input wire logic                   irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence pins_quiet;
      $stable(port_pin_input) && $past(port_pin_input) == $past(port_pin_input, 2)
         && $past(port_pin_input, 2) == $past(port_pin_input, 3);
   endsequence
   sequence flag_clear;
      reg_wr && reg_addr == `PEC_OFF_FLAGS && reg_wdata[5:0] == 6'h00;
   endsequence
   sequence men_off;
      reg_wr && reg_addr == `PEC_OFF_CTRL && !reg_wdata[`PEC_CTRL_MEN_BIT];
   endsequence
   a_wake_off: assert property (men_off |=> ##1 (!wake_req && !change_irq))
      else $error("wake without enable");
   a_wake_irq_same: assert property (wake_req == change_irq)
      else $error("wake differs");
   a_irq_needs_agg: assert property (change_irq |-> change_aggregate_flag)
      else $error("irq without flag");
   a_agg_sticky: assert property (change_aggregate_flag && !(reg_wr && reg_addr == `PEC_OFF_FLAGS)
      |=> change_aggregate_flag)
      else $error("flag lost");
   a_clear_empties: assert property (flag_clear ##0 pins_quiet |=> !change_aggregate_flag)
      else $error("clear failed");
   a_rise_cause: assert property ($rose(change_aggregate_flag) && !$past(reg_wr)
      |-> $past(port_pin_input, 3) != $past(port_pin_input, 4))
      else $error("flag without edge");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("rdata not idle");
   a_top_bits_zero: assert property ($past(reg_rd) && $past(reg_addr) <= `PEC_OFF_FLAGS
      |-> reg_rdata[7:6] == 2'h0)
      else $error("top bits set");
   a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > `PEC_OFF_IRQ_MASK
      |-> reg_rdata == 8'h00)
      else $error("unmapped read");
endmodule : pec_top_chk
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the edge change block
`timescale 1ns/1ps
`default_nettype none
`include "pec_params.svh"
module tb_top;
   logic               ref_clk = 1'b0;
   logic               rst_n = 1'b0;
   pec_pkg::pec_pins_t want = 6'h00;
   pec_pkg::pec_pins_t pins;
   logic [2:0]         reg_addr = 3'h0;
   pec_pkg::pec_byte_t reg_wdata = 8'h00;
   logic               reg_wr = 1'b0;
   logic               reg_rd = 1'b0;
   pec_pkg::pec_byte_t reg_rdata;
   logic               cirq, wake, agg, irq;
   int                 error_cnt = 0;
   int                 tests_run = 0;
   int                 cycles = 0;
   always #5 ref_clk = ~ref_clk;
   pec_pin_model u_pins (.want(want), .pins(pins));
   pec_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .port_pin_input(pins), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .change_irq(cirq), .wake_req(wake), .change_aggregate_flag(agg), .irq(irq));
   task automatic chk(input pec_pkg::pec_byte_t got, input pec_pkg::pec_byte_t exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input pec_pkg::pec_byte_t d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [2:0] a, input pec_pkg::pec_byte_t e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask : rd
   task automatic settle;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask : settle
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      for (int a = 0; a < 3; a++) rd(a[2:0], 8'h00);
      wr(`PEC_OFF_RISE, 8'hFF);
      wr(`PEC_OFF_FALL, 8'hFF);
      rd(`PEC_OFF_RISE, 8'h3F);
      rd(`PEC_OFF_FALL, 8'h3F);
      wr(`PEC_OFF_RISE, 8'h05);
      wr(`PEC_OFF_FALL, 8'h22);
      wr(`PEC_OFF_IRQ_MASK, 8'h01);
      want <= 6'h27;
      settle();
      rd(`PEC_OFF_FLAGS, 8'h05);
      chk({5'h00, wake, cirq, agg}, 8'h01);
      want <= 6'h00;
      settle();
      rd(`PEC_OFF_FLAGS, 8'h27);
      wr(`PEC_OFF_CTRL, 8'h01);
      settle();
      chk({6'h00, wake, cirq}, 8'h03);
      rd(`PEC_OFF_CTRL, 8'h03);
      wr(`PEC_OFF_FLAGS, 8'h27 & (8'hFF ^ 8'h27));
      settle();
      chk({6'h00, wake, agg}, 8'h00);
      want <= 6'h01;
      repeat (2) @(posedge ref_clk);
      #1;
      wr(`PEC_OFF_FLAGS, 8'h00);
      settle();
      rd(`PEC_OFF_FLAGS, 8'h01);
      rd(`PEC_OFF_IRQ_STAT, 8'h03);
      chk({7'h00, irq}, 8'h01);
      wr(`PEC_OFF_IRQ_STAT, 8'h03);
      wr(`PEC_OFF_IRQ_MASK, 8'h00);
      want <= 6'h05;
      settle();
      chk({7'h00, irq}, 8'h00);
      rd(`PEC_OFF_IRQ_STAT, 8'h01);
      wr(`PEC_OFF_IRQ_MASK, 8'h01);
      settle();
      chk({7'h00, irq}, 8'h01);
      wr(`PEC_OFF_CTRL, 8'h00);
      settle();
      chk({6'h00, wake, cirq}, 8'h00);
      rd(`PEC_OFF_CTRL, 8'h02);
      wr(3'h7, 8'hFF);
      rd(3'h7, 8'h00);
      print_verdict();
   end
endmodule : tb_top
bind pec_top pec_top_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .port_pin_input(port_pin_input), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .change_irq(change_irq),
   .wake_req(wake_req), .change_aggregate_flag(change_aggregate_flag), .irq(irq));
`default_nettype wire
